/* File: sitp_consts.vh */
// constants for the sensor two-wire target port
`ifndef SITP_CONSTS_VH
`define SITP_CONSTS_VH
`define SITP_ADDR_A 7'h10
`define SITP_ADDR_B 7'h11
`define SITP_CTRL_FIRST 8'h20
`define SITP_CTRL_LAST 8'h25
`define SITP_BIT_LAST 3'h7
`define SITP_CNT_ZERO 3'h0
`define SITP_ADDR_RST 8'h00
`define SITP_ST_IDLE 3'h0
`define SITP_ST_DEVADR 3'h1
`define SITP_ST_ACK 3'h2
`define SITP_ST_WRX 3'h3
`define SITP_ST_TX 3'h4
`define SITP_ST_MACK 3'h5
`define SITP_ST_IGNORE 3'h6
`endif

/* File: sitp_ctrl_mem.v */
// six-byte read/write control store, registered read
`timescale 1ns/1ps
`default_nettype none
`include "sitp_consts.vh"
module sitp_ctrl_mem (
  input wire sys_clk,
  input wire sys_rst,
  input wire clk_en,
  input wire wr_en,
  input wire [7:0] wr_addr,
  input wire [7:0] wr_data,
  input wire [7:0] rd_addr,
  output reg [7:0] rd_data
);
  reg [7:0] mem [0:5];
  wire wr_hit = (wr_addr >= `SITP_CTRL_FIRST) && (wr_addr <= `SITP_CTRL_LAST);
  wire rd_hit = (rd_addr >= `SITP_CTRL_FIRST) && (rd_addr <= `SITP_CTRL_LAST);
  wire [7:0] wr_off = wr_addr - `SITP_CTRL_FIRST;
  wire [7:0] rd_off = rd_addr - `SITP_CTRL_FIRST;
  integer i;
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      for (i = 0; i < 6; i = i + 1) begin
        mem[i] <= 8'h00;
      end
      rd_data <= 8'h00;
    end else if (clk_en) begin
      // other locations are read-only here: writes there are dropped
      if (wr_en && wr_hit) begin
        mem[wr_off[2:0]] <= wr_data;
      end
      rd_data <= rd_hit ? mem[rd_off[2:0]] : 8'h00;
    end
  end
endmodule
`default_nettype wire

/* File: sitp_master.sv */
// bus master model: drives scl, pulls sda low, samples the wire
`timescale 1ns/1ps
`default_nettype none
module sitp_master (
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // 400 ns bit, long low phase so target drive settles before rise
  task automatic bit_x(input logic b, output logic s);
    #100 sda_pull = ~b;
    #150 scl = 1'b1;
    #100 s = sda;
    #50 scl = 1'b0;
  endtask
  task automatic start_c;
    #100 sda_pull = 1'b1;
    #100 scl = 1'b0;
  endtask
  task automatic rstart_c;
    #100 sda_pull = 1'b0;
    #150 scl = 1'b1;
    #100 sda_pull = 1'b1;
    #100 scl = 1'b0;
  endtask
  task automatic stop_c;
    #100 sda_pull = 1'b1;
    #150 scl = 1'b1;
    #100 sda_pull = 1'b0;
    #100;
  endtask
  task automatic wr_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(v[i], s);
    bit_x(1'b1, s);
    ack = ~s;
  endtask
  task automatic rd_byte(input logic ack, output logic [7:0] v);
    logic s;
    for (int i = 0; i < 8; i++) begin
      bit_x(1'b1, s);
      v = {v[6:0], s};
    end
    bit_x(~ack, s);
  endtask
endmodule
`default_nettype wire

/* File: sitp_sync.v */
// two flip-flop synchroniser with edge-free output
`timescale 1ns/1ps
`default_nettype none
module sitp_sync (
  input wire sys_clk,
  input wire sys_rst,
  input wire clk_en,
  input wire din,
  output reg dout
);
  reg meta_reg;
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      meta_reg <= 1'b1;
      dout <= 1'b1;
    end else if (clk_en) begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule
`default_nettype wire

/* File: sitp_target.v */
// two-wire bus target port: framing, address match, register access
`timescale 1ns/1ps
`default_nettype none
`include "sitp_consts.vh"
module sitp_target (
  input wire sys_clk,
  input wire sys_rst,
  input wire clk_en,
  input wire scl_in,
  input wire sda_in,
  input wire addr_strap_pin_a,
  input wire addr_strap_pin_b,
  input wire open_drain_event_out,
  output reg sda_out,
  output reg sda_oe,
  output reg wr_strobe,
  output reg [7:0] wr_addr,
  output reg [7:0] wr_data,
  output reg busy
);
  wire scl_s;
  wire sda_s;
  wire stra_s;
  wire strb_s;
  wire evt_s;
  wire [7:0] mem_rd;
  sitp_sync u_scl (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .din(scl_in), .dout(scl_s));
  sitp_sync u_sda (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .din(sda_in), .dout(sda_s));
  sitp_sync u_sta (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .din(addr_strap_pin_a), .dout(stra_s));
  sitp_sync u_stb (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .din(addr_strap_pin_b), .dout(strb_s));
  sitp_sync u_evt (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .din(open_drain_event_out), .dout(evt_s));

  reg scl_d_reg;
  reg sda_d_reg;
  reg [2:0] state_reg;
  reg [2:0] bit_reg;
  reg [7:0] shift_reg;
  reg [7:0] addr_reg;
  reg [1:0] wbyte_reg;
  reg rd_mode_reg;
  reg sda_drv_reg;
  reg strap_reg;

  // a sampled bus clock of 20 MHz gives >=10 samples per phase at 1000 kHz
  wire scl_rise = scl_s && !scl_d_reg;
  wire scl_fall = !scl_s && scl_d_reg;
  wire start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  wire stop_det = scl_s && scl_d_reg && !sda_d_reg && sda_s;
  // strap a equal to the event pin with strap b differing selects address a; any other wiring selects address b
  wire strap_sel = (stra_s == evt_s) && (strb_s != evt_s);
  wire [6:0] own_addr = strap_reg ? `SITP_ADDR_A : `SITP_ADDR_B;
  wire [7:0] rx_byte = {shift_reg[6:0], sda_s};
  // strobe only for writable locations, so the port never reports a dropped byte
  wire ctrl_hit = (addr_reg >= `SITP_CTRL_FIRST) && (addr_reg <= `SITP_CTRL_LAST);

  function [7:0] next_addr;
    input [7:0] a;
    begin
      if (a == `SITP_CTRL_LAST) begin
        next_addr = `SITP_CTRL_FIRST;
      end else begin
        next_addr = a + 8'h01;
      end
    end
  endfunction

  sitp_ctrl_mem u_mem (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .wr_en(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_addr(addr_reg), .rd_data(mem_rd));

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      state_reg <= `SITP_ST_IDLE;
      bit_reg <= `SITP_CNT_ZERO;
      shift_reg <= 8'h00;
      addr_reg <= `SITP_ADDR_RST;
      wbyte_reg <= 2'h0;
      rd_mode_reg <= 1'b0;
      sda_drv_reg <= 1'b0;
      strap_reg <= 1'b1;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      wr_strobe <= 1'b0;
      wr_addr <= `SITP_ADDR_RST;
      wr_data <= 8'h00;
      busy <= 1'b0;
    end else if (clk_en) begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      wr_strobe <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= sda_drv_reg;
      busy <= (state_reg != `SITP_ST_IDLE) && (state_reg != `SITP_ST_IGNORE);
      // strap wiring sampled only while idle: synchroniser reset values are not real levels
      if (state_reg == `SITP_ST_IDLE && scl_s && sda_s) begin
        strap_reg <= strap_sel;
      end
      if (start_det) begin
        state_reg <= `SITP_ST_DEVADR;
        bit_reg <= `SITP_CNT_ZERO;
        sda_drv_reg <= 1'b0;
      end else if (stop_det) begin
        state_reg <= `SITP_ST_IDLE;
        sda_drv_reg <= 1'b0;
      end else begin
        case (state_reg)
          `SITP_ST_DEVADR, `SITP_ST_WRX: begin
            if (scl_rise) begin
              shift_reg <= rx_byte;
              bit_reg <= bit_reg + 3'h1;
            end
            if (scl_fall && bit_reg == `SITP_CNT_ZERO && wbyte_reg != 2'h3) begin
              if (state_reg == `SITP_ST_DEVADR) begin
                if (shift_reg[7:1] == own_addr) begin
                  rd_mode_reg <= shift_reg[0];
                  wbyte_reg <= 2'h0;
                  sda_drv_reg <= 1'b1;
                  state_reg <= `SITP_ST_ACK;
                end else begin
                  state_reg <= `SITP_ST_IGNORE;
                end
              end else begin
                if (wbyte_reg == 2'h0) begin
                  addr_reg <= shift_reg;
                  wbyte_reg <= 2'h1;
                end else begin
                  // the store drops bytes outside its range
                  wr_strobe <= ctrl_hit;
                  wr_addr <= addr_reg;
                  wr_data <= shift_reg;
                  addr_reg <= next_addr(addr_reg);
                end
                sda_drv_reg <= 1'b1;
                state_reg <= `SITP_ST_ACK;
              end
            end
            // wbyte_reg 3 marks the very first fall after start
            if (scl_fall && wbyte_reg == 2'h3) begin
              wbyte_reg <= 2'h0;
            end
          end
          `SITP_ST_ACK: begin
            // release the ack, or in read mode drive the first data bit, at the end of the ninth pulse, on scl low
            if (scl_fall) begin
              bit_reg <= `SITP_CNT_ZERO;
              if (rd_mode_reg) begin
                shift_reg <= mem_rd;
                sda_drv_reg <= ~mem_rd[7];
                addr_reg <= next_addr(addr_reg);
                state_reg <= `SITP_ST_TX;
              end else begin
                sda_drv_reg <= 1'b0;
                state_reg <= `SITP_ST_WRX;
              end
            end
          end
          `SITP_ST_TX: begin
            if (scl_fall) begin
              if (bit_reg == `SITP_BIT_LAST) begin
                sda_drv_reg <= 1'b0;
                state_reg <= `SITP_ST_MACK;
              end else begin
                bit_reg <= bit_reg + 3'h1;
                sda_drv_reg <= ~shift_reg[3'h6 - bit_reg];
              end
            end
          end
          `SITP_ST_MACK: begin
            if (scl_rise) begin
              if (sda_s) begin
                state_reg <= `SITP_ST_IGNORE;
              end else begin
                state_reg <= `SITP_ST_ACK;
              end
            end
          end
          `SITP_ST_IGNORE: begin
            sda_drv_reg <= 1'b0;
          end
          default: begin
            state_reg <= `SITP_ST_IDLE;
          end
        endcase
      end
      if (start_det) begin
        wbyte_reg <= 2'h3;
      end
    end
  end
endmodule
`default_nettype wire

/* File: sitp_target_props.sv */
// assertion checker on the ports of the two-wire target port
`timescale 1ns/1ps
`default_nettype none
module sitp_target_props (
  input wire sys_clk,
  input wire sys_rst,
  input wire scl_in,
  input wire sda_in,
  input wire sda_oe,
  input wire wr_strobe,
  input wire [7:0] wr_addr,
  input wire busy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sda_hold_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("sda drive changed while scl high");
  start_free_a: assert property ($fell(sda_in) && scl_in |-> !sda_oe)
    else $error("sda held low at a start");
  stop_idle_a: assert property ($rose(sda_in) && scl_in |-> ##[1:8] !busy)
    else $error("busy not cleared after stop");
  strobe_pulse_a: assert property (wr_strobe |=> !wr_strobe)
    else $error("write strobe longer than one cycle");
  strobe_range_a: assert property (wr_strobe |-> wr_addr >= 8'h20 && wr_addr <= 8'h25)
    else $error("write outside the control range");
  strobe_busy_a: assert property (wr_strobe |-> busy)
    else $error("write without an addressed transaction");
  strobe_low_a: assert property (wr_strobe |-> !scl_in)
    else $error("write strobe outside scl low");
  idle_quiet_a: assert property (!busy |-> !wr_strobe)
    else $error("write while not addressed");
endmodule
bind sitp_target sitp_target_props sitp_target_props_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .scl_in(scl_in), .sda_in(sda_in), .sda_oe(sda_oe), .wr_strobe(wr_strobe),
  .wr_addr(wr_addr), .busy(busy));
`default_nettype wire

/* File: tb_sitp_target.sv */
// self-checking bench for the two-wire target port
`timescale 1ns/1ps
`default_nettype none
module tb_sitp_target;
  logic sys_clk, sys_rst, scl, m_pull, sda_out, sda_oe, wr_strobe, busy, a;
  logic [7:0] wr_addr, wr_data, d;
  wire sda = ~(m_pull | (sda_oe & ~sda_out));
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  logic [15:0] wq [$];
  sitp_master sitp_master_i (.scl(scl), .sda_pull(m_pull), .sda(sda));
  // strap a equals event pin, strap b differs: own address 10h
  sitp_target sitp_target_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(1'b1),
    .scl_in(scl), .sda_in(sda), .addr_strap_pin_a(1'b0), .addr_strap_pin_b(1'b1),
    .open_drain_event_out(1'b0), .sda_out(sda_out), .sda_oe(sda_oe),
    .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data), .busy(busy));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task report_and_stop;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    if (wr_strobe === 1'b1) wq.push_back({wr_addr, wr_data});
    cycles++;
    if (cycles == 8000) begin
      failures++;
      report_and_stop;
    end
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task t_foreign;
    sitp_master_i.start_c;
    sitp_master_i.wr_byte(8'h22, a);
    chk({7'h0, a}, 8'h00);
    sitp_master_i.wr_byte(8'h20, a);
    chk({7'h0, a | busy}, 8'h00);
    sitp_master_i.stop_c;
  endtask
  task t_burst;
    wq = {};
    sitp_master_i.start_c;
    sitp_master_i.wr_byte(8'h20, a);
    chk({7'h0, a}, 8'h01);
    sitp_master_i.wr_byte(8'h24, a);
    for (int i = 0; i < 4; i++) begin
      sitp_master_i.wr_byte(8'ha1 + 8'(17 * i), a);
      chk({7'h0, a}, 8'h01);
    end
    sitp_master_i.stop_c;
    chk(8'(wq.size()), 8'h04);
    for (int i = 0; i < 4; i++) begin
      chk(wq[i][15:8], (i < 2) ? 8'(36 + i) : 8'(30 + i));
      chk(wq[i][7:0], 8'ha1 + 8'(17 * i));
    end
  endtask
  task t_readonly;
    wq = {};
    sitp_master_i.start_c;
    sitp_master_i.wr_byte(8'h20, a);
    sitp_master_i.wr_byte(8'h10, a);
    sitp_master_i.wr_byte(8'h5a, a);
    chk({7'h0, a}, 8'h01);
    sitp_master_i.stop_c;
    chk(8'(wq.size()), 8'h00);
  endtask
  task t_random;
    sitp_master_i.start_c;
    sitp_master_i.wr_byte(8'h20, a);
    sitp_master_i.wr_byte(8'h25, a);
    sitp_master_i.rstart_c;
    sitp_master_i.wr_byte(8'h21, a);
    chk({7'h0, a}, 8'h01);
    sitp_master_i.rd_byte(1'b1, d);
    chk(d, 8'hb2);
    sitp_master_i.rd_byte(1'b0, d);
    chk(d, 8'hc3);
    sitp_master_i.stop_c;
  endtask
  task t_current;
    sitp_master_i.start_c;
    sitp_master_i.wr_byte(8'h21, a);
    sitp_master_i.rd_byte(1'b0, d);
    chk(d, 8'hd4);
    sitp_master_i.stop_c;
  endtask
  initial begin
    sys_rst = 1'b1;
    repeat (6) @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (10) @(negedge sys_clk);
    t_foreign;
    t_burst;
    t_readonly;
    t_random;
    t_current;
    report_and_stop;
  end
endmodule
`default_nettype wire
